// ### rtl/gpc_port.v
// General-purpose 8-pin port with pin control and stop-mode retention.
// Assumes a byte register port on sys_clk_i, peripheral and analog
// overrides from on-chip logic on the same clock, and raw pin levels.
//
// Operation
// RL1 - Pins fall back to port control whenever no peripheral claims them.
// RL2 - Reset disables all peripheral overrides on the port pins.
// RL3 - Reset clears every direction bit, making all pins inputs.
// RL4 - Reset sets slew limiting, low drive, and pullups off per pin.
// RL5 - Each pin's direction bit enables its driver and steers data reads.
// RL6 - Direction 0: pin is input, data read returns sampled pin level.
// RL7 - Direction 1: pin drives latched data, read returns written value.
// RL8 - Under peripheral override the direction bit still steers data reads.
// RL9 - Analog function disables digital pin logic and reads back as 0.
// RL10 - Analog function beats an alternate digital function on one pin.
// RL11 - Software should write data before turning a pin into an output.
// RL12 - Pin control bits are independent of data and direction registers.
// RL13 - A set pullup enable turns on that pin's pullup.
// RL14 - Pullup forced off for outputs, peripheral outputs and analog pins.
// RL15 - Slew enable limits output edges and does nothing on inputs.
// RL16 - Drive select 1 gives high drive, 0 gives low drive.
// RL17 - Partial power-down stop holds the output latches as before stop.
// RL18 - On wake software checks the flag, then reinitialises or restores.
// RL19 - Software writes the acknowledge after restoring, before port use.
// RL20 - Powered stop keeps all port state and works at once on wake.
// RL21 - Flag reads 1 after partial power-down stop exit, else 0.
// RL22 - Writing 1 to the acknowledge bit clears the flag.
// RL23 - Pin levels pass a two-stage synchroniser before being read.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.vh"

module gpc_port (
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // Register port
  input  wire [2:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output wire [7:0]  reg_rdata_o,
  // Overrides from on-chip peripherals
  input  wire [7:0]  periph_en_i,
  input  wire [7:0]  periph_oe_i,
  input  wire [7:0]  periph_do_i,
  input  wire [7:0]  analog_en_i,
  // Stop request from the core, same clock
  input  wire        stop_i,
  // Pins
  input  wire [7:0]  pin_i,
  output wire [7:0]  pin_o,
  output wire [7:0]  pin_oe_o,
  output wire [7:0]  pullup_en_o,
  output wire [7:0]  slew_en_o,
  output wire [7:0]  drive_hi_o,
  output wire [7:0]  analog_sel_o,
  output wire        io_hold_o
);

  // ==========================================
  // Functions

  // Digital peripheral owns a pin unless analog claims it
  function [7:0] periph_own;
    input [7:0] gate;
    input [7:0] pen;
    input [7:0] aen;
    begin
      periph_own = gate & pen & ~aen; // RL10
    end
  endfunction

  // Effective output enable per pin
  function [7:0] eff_oe;
    input [7:0] own;
    input [7:0] poe;
    input [7:0] dir;
    input [7:0] aen;
    begin
      eff_oe = ((own & poe) | (~own & dir)) & ~aen; // RL1 RL5 RL9
    end
  endfunction

  // Write strobe aimed at one register index
  function wr_hit;
    input       wr;
    input [2:0] addr;
    input [2:0] ofs;
    begin
      wr_hit = wr & (addr == ofs);
    end
  endfunction

  // Status byte of the power register; unused bits read 0
  function [7:0] pmsc_byte;
    input flag;
    input sel;
    begin
      pmsc_byte                = `GPC_ZERO;
      pmsc_byte[`GPC_BIT_PARTIAL_POWERDOWN_FLAG] = flag;
      pmsc_byte[`GPC_BIT_PPDC] = sel;
    end
  endfunction

  // ==========================================
  // Declarations

  reg  [7:0] data_q;
  reg  [7:0] dir_q;
  reg  [7:0] pull_q;
  reg  [7:0] slew_q;
  reg  [7:0] drive_q;
  reg        ppdc_q;
  reg        partial_powerdown_flag_q;
  reg        partial_powerdown_flag_d;
  reg        stop_q;
  reg        periph_gate_q;
  reg  [7:0] rdata_q;
  reg  [7:0] rdata_d;

  reg  [7:0] out_q;
  reg  [7:0] oe_q;
  reg  [7:0] pu_q;
  reg  [7:0] sl_q;
  reg  [7:0] dh_q;
  reg  [7:0] an_q;

  wire [7:0] pin_sync;
  wire [7:0] own;
  wire [7:0] oe_d;
  wire [7:0] out_d;
  wire [7:0] pu_d;
  wire [7:0] sl_d;
  wire [7:0] dh_d;
  wire [7:0] port_rd;
  wire       wr_data;
  wire       wr_dir;
  wire       wr_pull;
  wire       wr_slew;
  wire       wr_drive;
  wire       wr_pmsc;
  wire       ppd_exit;
  wire       ppd_ack;
  wire       hold;
  wire [7:0] gate_vec;

  // ==========================================
  // Pin input synchroniser

  gpc_sync gpc_sync_inst (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (pin_i),
    .sync_o    (pin_sync)
  ); // RL23

  // ==========================================
  // Write decode

  assign wr_data  = wr_hit(reg_wr_i, reg_addr_i, `GPC_OFS_DATA);
  assign wr_dir   = wr_hit(reg_wr_i, reg_addr_i, `GPC_OFS_DIR);
  assign wr_pull  = wr_hit(reg_wr_i, reg_addr_i, `GPC_OFS_PULL);
  assign wr_slew  = wr_hit(reg_wr_i, reg_addr_i, `GPC_OFS_SLEW);
  assign wr_drive = wr_hit(reg_wr_i, reg_addr_i, `GPC_OFS_DRIVE);
  assign wr_pmsc  = wr_hit(reg_wr_i, reg_addr_i, `GPC_OFS_PMSC2);

  // ==========================================
  // Port data and direction registers
  // Data writes latch all bits, whatever the direction

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_q <= `GPC_RST_DATA;
      dir_q  <= `GPC_RST_DIR; // RL3
    end else begin
      if (wr_data) begin
        data_q <= reg_wdata_i;
      end
      if (wr_dir) begin
        dir_q <= reg_wdata_i;
      end
    end
  end

  // ==========================================
  // Pin control registers
  // Own strobes only, so data or direction writes never touch them

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pull_q  <= `GPC_RST_PULL;  // RL4
      slew_q  <= `GPC_RST_SLEW;  // RL4
      drive_q <= `GPC_RST_DRIVE; // RL4
    end else begin
      if (wr_pull) begin
        pull_q <= reg_wdata_i; // RL12
      end
      if (wr_slew) begin
        slew_q <= reg_wdata_i; // RL12
      end
      if (wr_drive) begin
        drive_q <= reg_wdata_i; // RL12
      end
    end
  end

  // ==========================================
  // Power management: stop mode select, flag and acknowledge

  assign ppd_exit = stop_q & ~stop_i & ppdc_q;
  assign ppd_ack  = wr_pmsc & reg_wdata_i[`GPC_BIT_PARTIAL_POWERDOWN_ACK];

  // Set wins over a same-cycle acknowledge so no exit is lost
  always @* begin
    partial_powerdown_flag_d = partial_powerdown_flag_q;
    if (ppd_ack) begin
      partial_powerdown_flag_d = `GPC_OFF; // RL22
    end
    if (ppd_exit) begin
      partial_powerdown_flag_d = `GPC_ON; // RL21
    end
  end

  // Stop level of the previous cycle, for exit detection
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stop_q <= `GPC_OFF;
    end else begin
      stop_q <= stop_i;
    end
  end

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      partial_powerdown_flag_q <= `GPC_OFF;
    end else begin
      partial_powerdown_flag_q <= partial_powerdown_flag_d;
    end
  end

  // Mode select is not changed while stopped, so a stop
  // always ends in the mode it began in
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ppdc_q <= `GPC_OFF;
    end else if (wr_pmsc & ~stop_i) begin
      ppdc_q <= reg_wdata_i[`GPC_BIT_PPDC];
    end
  end

  // Latches freeze in partial power-down stop and stay frozen
  // until software acknowledges the recovery; the exit cycle
  // is covered too, since the flag only sets at its end.
  // Powered stop never freezes anything
  assign hold = (stop_i & ppdc_q) | ppd_exit | partial_powerdown_flag_q; // RL17 RL19 RL20

  // ==========================================
  // Peripheral gate
  // Cleared by reset and opened on the first edge after release

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      periph_gate_q <= `GPC_OFF; // RL2
    end else begin
      periph_gate_q <= `GPC_ON;
    end
  end

  // One gate bit fans out to every pin of the port
  assign gate_vec = {`GPC_W{periph_gate_q}}; // RL2

  // ==========================================
  // Pin-side output logic

  assign own   = periph_own(gate_vec, periph_en_i, analog_en_i);
  assign oe_d  = eff_oe(own, periph_oe_i, dir_q, analog_en_i);
  assign out_d = ((own & periph_do_i) | (~own & data_q)) & ~analog_en_i; // RL1 RL7
  assign pu_d  = pull_q & ~oe_d & ~analog_en_i; // RL13 RL14
  assign sl_d  = slew_q & oe_d; // RL15
  assign dh_d  = drive_q & oe_d; // RL16

  // Registered pin drive; a held latch keeps the pre-stop state
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_q <= `GPC_ZERO;
      oe_q  <= `GPC_ZERO;
      pu_q  <= `GPC_ZERO;
      sl_q  <= `GPC_ZERO;
      dh_q  <= `GPC_ZERO;
      an_q  <= `GPC_ZERO;
    end else if (!hold) begin
      out_q <= out_d;
      oe_q  <= oe_d;
      pu_q  <= pu_d;
      sl_q  <= sl_d;
      dh_q  <= dh_d;
      an_q  <= analog_en_i; // RL10
    end
  end

  assign pin_o        = out_q;
  assign pin_oe_o     = oe_q;
  assign pullup_en_o  = pu_q;
  assign slew_en_o    = sl_q;
  assign drive_hi_o   = dh_q;
  assign analog_sel_o = an_q;
  assign io_hold_o    = hold;

  // ==========================================
  // Read path
  // Direction alone steers data reads, even under peripheral control

  assign port_rd = ((dir_q & data_q) | (~dir_q & pin_sync))
                   & ~analog_en_i; // RL6 RL7 RL8 RL9

  always @* begin
    rdata_d = `GPC_ZERO;
    case (reg_addr_i)
      `GPC_OFS_DATA:  rdata_d = port_rd;
      `GPC_OFS_DIR:   rdata_d = dir_q;
      `GPC_OFS_PULL:  rdata_d = pull_q;
      `GPC_OFS_SLEW:  rdata_d = slew_q;
      `GPC_OFS_DRIVE: rdata_d = drive_q;
      `GPC_OFS_PMSC2: rdata_d = pmsc_byte(partial_powerdown_flag_q, ppdc_q); // RL21
      default:        rdata_d = `GPC_ZERO;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= `GPC_ZERO;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= `GPC_ZERO;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule // gpc_port

`default_nettype wire

// ### rtl/gpc_defines.vh
// Constants for the general-purpose port block: offsets, fields, resets.
// Assumes an 8-pin port on a byte-wide register port.
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH

`define GPC_W            8
`define GPC_AW           3

`define GPC_OFS_DATA     3'h0
`define GPC_OFS_DIR      3'h1
`define GPC_OFS_PULL     3'h2
`define GPC_OFS_SLEW     3'h3
`define GPC_OFS_DRIVE    3'h4
`define GPC_OFS_PMSC2    3'h5

`define GPC_BIT_PARTIAL_POWERDOWN_FLAG     3
`define GPC_BIT_PARTIAL_POWERDOWN_ACK   2
`define GPC_BIT_PPDC     0

`define GPC_RST_DATA     8'h00
`define GPC_RST_DIR      8'h00
`define GPC_RST_PULL     8'h00
`define GPC_RST_SLEW     8'hFF
`define GPC_RST_DRIVE    8'h00
`define GPC_ZERO         8'h00
`define GPC_OFF          1'h0
`define GPC_ON           1'h1

`endif

// ### rtl/gpc_sync.v
// Two-stage synchroniser for the port's pin input levels.
// Assumes asynchronous pin levels and one system clock.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.vh"

module gpc_sync (
  input  wire       sys_clk_i,
  input  wire       sys_rst_i,
  input  wire [7:0] async_i,
  output wire [7:0] sync_o
);

  reg [7:0] meta_q;
  reg [7:0] stable_q;

  // ==========================================
  // Capture stages
  // First stage feeds only the second one to bound metastability
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q   <= `GPC_ZERO;
      stable_q <= `GPC_ZERO;
    end else begin
      meta_q   <= async_i;
      stable_q <= meta_q;
    end
  end

  assign sync_o = stable_q;

endmodule // gpc_sync

`default_nettype wire

// ### sim/gpc_port_chk.sv
// Concurrent checks on the ports of gpc_port.
// Assumes one clock domain and the asynchronous high reset.
`timescale 1ns/1ps
`default_nettype none

module gpc_port_chk (
  input wire       sys_clk_i,
  input wire       sys_rst_i,
  input wire [2:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire       stop_i,
  input wire [7:0] pin_o,
  input wire [7:0] pin_oe_o,
  input wire [7:0] pullup_en_o,
  input wire [7:0] slew_en_o,
  input wire [7:0] drive_hi_o,
  input wire [7:0] analog_sel_o,
  input wire       io_hold_o
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_pull_out_off: assert property ((pullup_en_o & pin_oe_o) == 8'h00)
    else $error("pullup on while driving");
  a_pull_ana_off: assert property ((pullup_en_o & analog_sel_o) == 8'h00)
    else $error("pullup on an analog pin");
  a_slew_when_out: assert property ((slew_en_o & ~pin_oe_o) == 8'h00)
    else $error("slew limit on an input");
  a_drive_when_out: assert property ((drive_hi_o & ~pin_oe_o) == 8'h00)
    else $error("high drive on an input");
  a_analog_no_drive: assert property ((pin_oe_o & analog_sel_o) == 8'h00)
    else $error("analog pin still driven");
  // Peripheral requests are gated for the first edge, so nothing drives yet
  a_reset_inputs: assert property ($fell(sys_rst_i) |=> (pin_oe_o | pullup_en_o) == 8'h00)
    else $error("pin not a plain input after reset");
  a_hold_freezes: assert property ($past(io_hold_o) |-> $stable(pin_o) && $stable(pin_oe_o))
    else $error("pin latch moved while held");
  a_exit_holds: assert property ($past(stop_i) && !stop_i && $past(io_hold_o)
    && !$past(reg_wr_i) |-> io_hold_o)
    else $error("latches released at stop exit");
  a_ack_release: assert property (reg_wr_i && reg_addr_i == 3'h5 && reg_wdata_i[2]
    && !stop_i && !$past(stop_i) |=> !io_hold_o || stop_i)
    else $error("hold stays after acknowledge");

  c_hold: cover property ($rose(io_hold_o));
  c_analog: cover property ((analog_sel_o & ~pin_oe_o) != 8'h00 && pin_oe_o != 8'h00);
  c_read: cover property (reg_rd_i ##1 reg_wr_i);
endmodule // gpc_port_chk

bind gpc_port gpc_port_chk gpc_port_chk_inst (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .stop_i(stop_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o),
  .slew_en_o(slew_en_o), .drive_hi_o(drive_hi_o), .analog_sel_o(analog_sel_o),
  .io_hold_o(io_hold_o));

`default_nettype wire

// ### sim/gpc_pin_model.sv
// Behavioural model of the eight pads and whatever hangs on them.
// Assumes the port's driver outputs and a bench-set external level.
`timescale 1ns/1ps
`default_nettype none

module gpc_pin_model (
  input  wire        sys_clk_i,
  input  wire  [7:0] drv_data_i,
  input  wire  [7:0] drv_en_i,
  input  wire  [7:0] pull_en_i,
  input  wire  [7:0] ext_en_i,
  input  wire  [7:0] ext_lvl_i,
  output logic [7:0] pin_lvl_o
);
  // ==========================================================
  // Pad level
  // A floating pad toggles so a stale value can never read back by luck
  logic [7:0] float_q;
  initial float_q = 8'h55;
  always @(posedge sys_clk_i) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv_en_i[i]) pin_lvl_o[i] = drv_data_i[i];
      else if (ext_en_i[i]) pin_lvl_o[i] = ext_lvl_i[i];
      else if (pull_en_i[i]) pin_lvl_o[i] = 1'h1;
      else pin_lvl_o[i] = float_q[i];
    end
  end
endmodule // gpc_pin_model

`default_nettype wire

// ### sim/gpc_port_tb_top.sv
// Self-checking bench for gpc_port with the pad model.
// Assumes the rtl/ sources and gpc_defines.vh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.vh"

module gpc_port_tb_top;
  logic       sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, stop_i, io_hold_o;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, periph_en_i, periph_oe_i, periph_do_i;
  logic [7:0] analog_en_i, pin_i, pin_o, pin_oe_o, pullup_en_o, slew_en_o;
  logic [7:0] drive_hi_o, analog_sel_o, ext_en, ext_lvl;
  int         err_count, compares;

  gpc_port gpc_port_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .periph_en_i(periph_en_i),
    .periph_oe_i(periph_oe_i), .periph_do_i(periph_do_i), .analog_en_i(analog_en_i),
    .stop_i(stop_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pullup_en_o(pullup_en_o), .slew_en_o(slew_en_o), .drive_hi_o(drive_hi_o),
    .analog_sel_o(analog_sel_o), .io_hold_o(io_hold_o));
  gpc_pin_model gpc_pin_model_inst (.sys_clk_i(sys_clk_i), .drv_data_i(pin_o),
    .drv_en_i(pin_oe_o), .pull_en_i(pullup_en_o), .ext_en_i(ext_en),
    .ext_lvl_i(ext_lvl), .pin_lvl_o(pin_i));

  // ==========================================================
  // Tasks
  task chk(input [7:0] seen, input [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Strobes drop for one idle cycle, so no signal is set twice in a step
  task wr(input [2:0] a, input [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    tick(1);
    reg_wr_i <= 1'h0;
    tick(1);
  endtask
  task rd(input [2:0] a, input [7:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    tick(1);
    reg_rd_i <= 1'h0;
    chk(reg_rdata_o, exp);
    tick(1);
  endtask
  task conclude;
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and sequence
  initial begin
    sys_clk_i = 1'h0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    err_count++;
    conclude();
  end
  initial begin
    {reg_wr_i, reg_rd_i, stop_i, reg_addr_i, reg_wdata_i, analog_en_i} = '0;
    {periph_en_i, periph_oe_i, periph_do_i} = {3{8'hFF}};
    sys_rst_i = 1'h1;
    ext_en = 8'hFF;
    ext_lvl = 8'hA5;
    tick(1);
    chk(pin_oe_o, 8'h00);
    {periph_en_i, periph_oe_i, periph_do_i} <= '0;
    tick(1);
    sys_rst_i <= 1'h0;
    tick(3);
    chk(pin_oe_o, 8'h00);
    chk(pullup_en_o | slew_en_o | drive_hi_o, 8'h00);
    rd(`GPC_OFS_DATA, 8'hA5);
    rd(`GPC_OFS_DIR, `GPC_RST_DIR);
    rd(`GPC_OFS_PULL, `GPC_RST_PULL);
    rd(`GPC_OFS_SLEW, `GPC_RST_SLEW);
    rd(`GPC_OFS_DRIVE, `GPC_RST_DRIVE);
    rd(`GPC_OFS_PMSC2, 8'h00);
    ext_lvl = 8'h5A;
    rd(`GPC_OFS_DATA, 8'hA5);
    rd(`GPC_OFS_DATA, 8'h5A);
    $display("Test reset finished");
    ext_lvl = 8'h3C;
    wr(`GPC_OFS_DATA, 8'hC3);
    wr(`GPC_OFS_DIR, 8'h0F);
    chk(pin_oe_o, 8'h0F);
    chk(pin_o & pin_oe_o, 8'h03);
    rd(`GPC_OFS_DATA, 8'h33);
    wr(`GPC_OFS_PULL, 8'hFF);
    wr(`GPC_OFS_SLEW, 8'h00);
    wr(`GPC_OFS_DRIVE, 8'hF0);
    chk(pullup_en_o, 8'hF0);
    chk(slew_en_o | drive_hi_o, 8'h00);
    rd(`GPC_OFS_DIR, 8'h0F);
    ext_en = 8'h00;
    tick(3);
    rd(`GPC_OFS_DATA, 8'hF3);
    ext_en = 8'hFF;
    wr(`GPC_OFS_SLEW, 8'hFF);
    wr(`GPC_OFS_DRIVE, 8'h3C);
    chk(slew_en_o, 8'h0F);
    chk(drive_hi_o, 8'h0C);
    rd(`GPC_OFS_DATA, 8'h33);
    $display("Test direction and pin control finished");
    {periph_en_i, periph_oe_i, periph_do_i} <= {8'hF0, 8'h30, 8'h20};
    tick(4);
    chk(pin_oe_o, 8'h3F);
    chk(pin_o & pin_oe_o, 8'h23);
    chk(pullup_en_o, 8'hC0);
    rd(`GPC_OFS_DATA, 8'h23);
    {periph_en_i, periph_oe_i, analog_en_i} <= {8'h80, 8'h80, 8'h81};
    tick(4);
    chk(analog_sel_o, 8'h81);
    chk(pin_oe_o, 8'h0E);
    chk(pullup_en_o, 8'h70);
    rd(`GPC_OFS_DATA, 8'h32);
    {periph_en_i, analog_en_i} <= '0;
    tick(2);
    chk(pin_oe_o, 8'h0F);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    rd(`GPC_OFS_DIR, 8'h0F);
    $display("Test overrides finished");
    wr(`GPC_OFS_PMSC2, 8'h01);
    stop_i <= 1'h1;
    tick(1);
    chk({7'h00, io_hold_o}, 8'h01);
    wr(`GPC_OFS_DATA, 8'h5A);
    stop_i <= 1'h0;
    tick(2);
    chk(pin_o & pin_oe_o, 8'h03);
    rd(`GPC_OFS_PMSC2, 8'h09);
    wr(`GPC_OFS_PMSC2, 8'h05);
    chk({7'h00, io_hold_o}, 8'h00);
    chk(pin_o & pin_oe_o, 8'h0A);
    rd(`GPC_OFS_PMSC2, 8'h01);
    wr(`GPC_OFS_PMSC2, 8'h00);
    stop_i <= 1'h1;
    wr(`GPC_OFS_DATA, 8'hA5);
    chk({7'h00, io_hold_o}, 8'h00);
    chk(pin_o & pin_oe_o, 8'h05);
    stop_i <= 1'h0;
    tick(2);
    rd(`GPC_OFS_PMSC2, 8'h00);
    $display("Test stop modes finished");
    sys_rst_i <= 1'h1;
    {periph_en_i, periph_oe_i} <= {2{8'hFF}};
    tick(2);
    sys_rst_i <= 1'h0;
    tick(1);
    chk(pin_oe_o, 8'h00);
    tick(1);
    chk(pin_oe_o, 8'hFF);
    rd(`GPC_OFS_DIR, `GPC_RST_DIR);
    rd(`GPC_OFS_SLEW, `GPC_RST_SLEW);
    $display("Test second reset finished");
    conclude();
  end
endmodule // gpc_port_tb_top

`default_nettype wire
